// File: src/fpc_pkg.sv
// Constants, types and state for the fuse personalization command block.
// Assumes a framing layer delivers whole decoded commands and a separate
// hash core and fuse array sit outside this block.
//
// Contract
// - Digest command opcode 0x20, key, 16-byte seed.
// - Digest ready flag set; cleared on watchdog/power.
// - Digest command fails when lock fuse 87 burned.
// - Hash block key, ones, seed, pad, length.
// - Digest command success returns single zero byte.
// - No readout path for key or digest.
// - Burn command opcode 0x10, flag, duration, map.
// - Map one bits burn fuses, zero-first ordering.
// - Decrypt flag XORs map with digest bits.
// - Duration 0 gives 250us, 0x8000 190ms each.
// - Burn time scales with count, no check.
// - Burn refused when lock fuse 87 burned.
// - Burn success returns single zero byte.
// - No readback of 64 secret fuses.
// - Pause opcode 0x01; busy till watchdog, ignore IO.
// - Selector zero pauses all silently.
// - Nonzero selector matches fuses 84-87, else 0x0f.
package fpc_pkg;

  // ----------------------------------------------------------------
  // Opcodes and answers
  // ----------------------------------------------------------------
  localparam logic [7:0] FPC_OP_DIGEST = 8'h20; // Digest opcode
  localparam logic [7:0] FPC_OP_BURN = 8'h10;   // Fuse map burn opcode
  localparam logic [7:0] FPC_OP_PAUSE = 8'h01;  // Long pause opcode
  localparam logic [7:0] FPC_RESP_OK = 8'h00;   // Success byte
  localparam logic [7:0] FPC_RESP_OTHER = 8'h0f; // Other chip paused
  localparam logic [7:0] FPC_RESP_ERR = 8'h0f;  // Generic error code
  localparam logic [15:0] FPC_DUR_LOW = 16'h8000; // Low supply duration

  // ----------------------------------------------------------------
  // Fuse layout
  // ----------------------------------------------------------------
  localparam int FPC_NFUSE = 88;     // Burnable fuses
  localparam int FPC_LOCK_FUSE = 87; // Personalization lock fuse
  localparam int FPC_SEL_LO = 84;    // First selector fuse
  localparam logic [63:0] FPC_LEN_447 = 64'h0000_0000_0000_01bf;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int FPC_CLK_MHZ = 40;     // Clock rate
  localparam int FPC_HI_BURN_US = 250; // Burn time, high supply
  localparam int FPC_LO_BURN_MS = 190; // Burn time per fuse, low supply
  localparam int FPC_HI_CYC = FPC_HI_BURN_US * FPC_CLK_MHZ;
  localparam int FPC_LO_CYC = FPC_LO_BURN_MS * 1000 * FPC_CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    FPC_IDLE = 6'b000001, // Waiting for command
    FPC_HASH = 6'b000010, // Digest in progress
    FPC_SCAN = 6'b000100, // Find next fuse to burn
    FPC_BURN = 6'b001000, // Burning one fuse
    FPC_BUSY = 6'b010000, // Pause busy, wait watchdog
    FPC_PAUS = 6'b100000  // Paused
  } fpc_state_e;

  typedef struct packed {
    logic [7:0] opcode;   // Command code
    logic [7:0] param1;   // First parameter
    logic [15:0] param2;  // Second parameter
    logic [127:0] data;   // Payload, first byte in [127:120]
  } fpc_cmd_s;

  typedef struct packed {
    logic valid;      // One-cycle answer strobe
    logic err;        // Error answer
    logic [7:0] code; // Answer byte
  } fpc_resp_s;

endpackage

// File: src/fpc_msg_build.sv
// Builds the 512-bit digest input block from key and seed.
// Assumes key and seed are stable while the hash core runs.
`timescale 1ns/1ps
module fpc_msg_build (
  input wire logic [255:0] key,
  input wire logic [127:0] seed,
  output logic [511:0] block
);
  // ----------------------------------------------------------------
  // Block layout
  // ----------------------------------------------------------------
  // Key, ones, seed without last bit, pad one, length
  assign block = {key, {64{1'b1}}, seed[127:1], 1'b1,
                  fpc_pkg::FPC_LEN_447};
endmodule

// File: src/fpc_burn_timer.sv
// Counts cycles of one fuse burn.
// Assumes start is a one-cycle pulse while idle.
`timescale 1ns/1ps
module fpc_burn_timer (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [31:0] cycles,
  output logic done
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic run;         // Timer active
    logic [31:0] cnt;  // Cycles left
    logic done;        // End pulse
  } fpc_tmr_s;
  fpc_tmr_s s_q, s_d;

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.run = 1'b1;
      s_d.cnt = cycles;
    end else if (s_q.run) begin
      if (s_q.cnt <= 32'h1) begin
        s_d.run = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 32'h1;
      end
    end
  end

  // Register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
endmodule

// File: src/fpc_top.sv
// Command engine for digest, fuse map burn and long pause commands.
// Assumes a framing layer supplies decoded commands one at a time, an
// outside hash core and fuse array, and a watchdog expiry pulse.
`timescale 1ns/1ps
module fpc_top #(
  parameter int LO_BURN_CYC = fpc_pkg::FPC_LO_CYC // Low supply burn
) (
  input wire logic sys_clk,
  input wire logic srst,
  // Decoded command in
  input wire logic cmd_valid,
  input wire fpc_pkg::fpc_cmd_s cmd,
  output logic cmd_ready,
  // Answer out
  output fpc_pkg::fpc_resp_s resp,
  // Key table lookup
  output logic [15:0] key_index,
  input wire logic [255:0] key_value,
  // Hash core
  output logic hash_start,
  output logic [511:0] hash_block,
  input wire logic hash_done,
  input wire logic [255:0] hash_digest,
  // Fuse array
  input wire logic [87:0] fuse_state,
  output logic fuse_burn,
  output logic [6:0] fuse_num,
  // Watchdog
  input wire logic wdt_expire,
  // Status
  output logic digest_ready,
  output logic io_ignore
);
  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    fpc_pkg::fpc_state_e st;   // Main state
    logic rdy;                 // Digest valid flag
    logic [87:0] pad;          // Stored digest bits for decryption
    logic [127:0] seed;        // Latched seed
    logic [15:0] kidx;         // Latched key index
    logic [87:0] map;          // Remaining fuses to burn
    logic [6:0] idx;           // Current fuse
    logic lowv;                // Low supply duration selected
    logic hstart;              // Hash start pulse
    logic bstart;              // Burn start pulse
    fpc_pkg::fpc_resp_s resp;  // Answer register
  } fpc_top_s;
  fpc_top_s s_q, s_d;

  logic tmr_done; // Burn timer finished
  logic lock_burned; // Fuse 87 burned
  logic [3:0] sel_fuses; // Fuses 84-87

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // A burned fuse reads as zero in the array
  assign lock_burned = ~fuse_state[fpc_pkg::FPC_LOCK_FUSE];
  assign sel_fuses = fuse_state[fpc_pkg::FPC_SEL_LO +: 4];

  // Digest input block assembly
  fpc_msg_build u_msg (
    .key(key_value),
    .seed(s_q.seed),
    .block(hash_block)
  );

  // Per-fuse burn time
  fpc_burn_timer u_tmr (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(s_q.bstart),
    .cycles(s_q.lowv ? 32'(LO_BURN_CYC) :
            32'(fpc_pkg::FPC_HI_CYC)),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.hstart = 1'b0;
    s_d.bstart = 1'b0;
    s_d.resp = '0;
    case (s_q.st)
      // Take a new command
      fpc_pkg::FPC_IDLE: begin
        if (cmd_valid) begin
          case (cmd.opcode)
            fpc_pkg::FPC_OP_DIGEST: begin
              if (lock_burned) begin
                // Refuse, nothing changes
                s_d.resp = '{valid: 1'b1, err: 1'b1,
                             code: fpc_pkg::FPC_RESP_ERR};
              end else begin
                s_d.seed = cmd.data;
                s_d.kidx = cmd.param2;
                s_d.rdy = 1'b0;
                s_d.hstart = 1'b1;
                s_d.st = fpc_pkg::FPC_HASH;
              end
            end
            fpc_pkg::FPC_OP_BURN: begin
              if (lock_burned) begin
                // Refuse before any burn
                s_d.resp = '{valid: 1'b1, err: 1'b1,
                             code: fpc_pkg::FPC_RESP_ERR};
              end else begin
                // Map first byte holds fuses 0..7, bit 0 first
                for (int i = 0; i < fpc_pkg::FPC_NFUSE; i++) begin
                  s_d.map[i] = cmd.data[127 - 8 * (i / 8) - 7 + (i % 8)];
                end
                // Decrypt with stored digest
                if (cmd.param1 == 8'h01) begin
                  s_d.map = s_d.map ^ (s_q.rdy ? s_q.pad : 88'h0);
                end
                s_d.lowv = (cmd.param2 == fpc_pkg::FPC_DUR_LOW);
                s_d.idx = '0;
                s_d.st = fpc_pkg::FPC_SCAN;
              end
            end
            fpc_pkg::FPC_OP_PAUSE: begin
              if (cmd.param1 == 8'h00 ||
                  sel_fuses == cmd.param1[3:0]) begin
                // Silent pause
                s_d.st = fpc_pkg::FPC_BUSY;
              end else begin
                // Other chip targeted
                s_d.resp = '{valid: 1'b1, err: 1'b0,
                             code: fpc_pkg::FPC_RESP_OTHER};
              end
            end
            default: begin
              // Not handled here
              s_d.resp = '{valid: 1'b1, err: 1'b1,
                           code: fpc_pkg::FPC_RESP_ERR};
            end
          endcase
        end
      end
      // Wait for hash core
      fpc_pkg::FPC_HASH: begin
        if (hash_done) begin
          // Keep only bits used for decryption
          s_d.pad = hash_digest[255 -: 88];
          s_d.rdy = 1'b1;
          s_d.resp = '{valid: 1'b1, err: 1'b0,
                       code: fpc_pkg::FPC_RESP_OK};
          s_d.st = fpc_pkg::FPC_IDLE;
        end
      end
      // Find next set map bit; one burn per set bit
      fpc_pkg::FPC_SCAN: begin
        if (s_q.idx == 7'(fpc_pkg::FPC_NFUSE)) begin
          s_d.resp = '{valid: 1'b1, err: 1'b0,
                       code: fpc_pkg::FPC_RESP_OK};
          s_d.st = fpc_pkg::FPC_IDLE;
        end else if (s_q.map[s_q.idx]) begin
          s_d.bstart = 1'b1;
          s_d.st = fpc_pkg::FPC_BURN;
        end else begin
          s_d.idx = s_q.idx + 7'h1;
        end
      end
      // Hold burn strobe until timer ends
      fpc_pkg::FPC_BURN: begin
        if (tmr_done) begin
          s_d.idx = s_q.idx + 7'h1;
          s_d.st = fpc_pkg::FPC_SCAN;
        end
      end
      // Busy until watchdog expires
      fpc_pkg::FPC_BUSY: begin
        if (wdt_expire) begin
          s_d.st = fpc_pkg::FPC_PAUS;
        end
      end
      // Paused; leaves only by reset
      fpc_pkg::FPC_PAUS: begin
        s_d.st = fpc_pkg::FPC_PAUS;
      end
      default: begin
        s_d.st = fpc_pkg::FPC_IDLE;
      end
    endcase
    // Watchdog drops the digest
    if (wdt_expire) begin
      s_d.rdy = 1'b0;
      s_d.pad = '0;
    end
  end

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '{st: fpc_pkg::FPC_IDLE, default: '0}; // Power loss
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmd_ready = (s_q.st == fpc_pkg::FPC_IDLE);
  assign resp = s_q.resp;
  assign key_index = s_q.kidx;
  assign hash_start = s_q.hstart;
  assign fuse_burn = (s_q.st == fpc_pkg::FPC_BURN);
  assign fuse_num = s_q.idx;
  // Fuse states only enter; no fuse readout port
  assign digest_ready = s_q.rdy;
  // Ignore the wire while busy or paused
  assign io_ignore = (s_q.st == fpc_pkg::FPC_BUSY) ||
                     (s_q.st == fpc_pkg::FPC_PAUS);
endmodule

// File: dv/fpc_top_properties.sv
// Checker for the fuse personalization command engine.
// Assumes it is bound to fpc_top and sees only that module's ports.
`timescale 1ns/1ps
module fpc_chk (
  input logic sys_clk,
  input logic srst,
  input logic cmd_valid,
  input fpc_pkg::fpc_cmd_s cmd,
  input logic cmd_ready,
  input fpc_pkg::fpc_resp_s resp,
  input logic hash_start,
  input logic hash_done,
  input logic [87:0] fuse_state,
  input logic fuse_burn,
  input logic wdt_expire,
  input logic digest_ready,
  input logic io_ignore
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic tk; // Command taken at this edge
  logic lk; // Lock fuse reads burned
  assign tk = cmd_valid && cmd_ready;
  assign lk = !fuse_state[87];
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  lock_refuse_a: assert property (
    tk && lk && cmd.opcode inside {8'h20, 8'h10}
    |=> resp.valid && resp.err && resp.code == 8'h0f)
    else $error("locked command not refused");
  refuse_still_a: assert property (
    tk && lk && cmd.opcode inside {8'h20, 8'h10}
    |=> (!fuse_burn && !hash_start) [*4])
    else $error("refused command changed state");
  digest_start_a: assert property (
    tk && !lk && cmd.opcode == 8'h20 |=> hash_start ##1 !hash_start)
    else $error("digest did not start hash");
  digest_ok_a: assert property (
    hash_done |=> resp.valid && !resp.err && resp.code == 8'h00
    && digest_ready)
    else $error("digest answer wrong");
  wdt_clear_a: assert property (
    wdt_expire |=> !digest_ready)
    else $error("digest flag kept past watchdog");
  pause_all_a: assert property (
    tk && cmd.opcode == 8'h01 && cmd.param1 == 8'h00
    |=> io_ignore && !resp.valid)
    else $error("broadcast pause wrong");
  pause_miss_a: assert property (
    tk && cmd.opcode == 8'h01 && cmd.param1 != 8'h00
    && cmd.param1[3:0] != fuse_state[87:84]
    |=> resp.valid && resp.code == 8'h0f && !io_ignore)
    else $error("pause mismatch answer wrong");
  pause_hold_a: assert property (
    io_ignore |=> io_ignore && !resp.valid)
    else $error("pause left or answered");
  burn_hold_a: assert property (
    $rose(fuse_burn) |-> fuse_burn [*8])
    else $error("fuse burn too short");
endmodule

bind fpc_top fpc_chk u_chk (.sys_clk, .srst, .cmd_valid, .cmd,
  .cmd_ready, .resp, .hash_start, .hash_done, .fuse_state, .fuse_burn,
  .wdt_expire, .digest_ready, .io_ignore);

// File: dv/fpc_far_model.sv
// Far side model: key table, hash core and fuse array.
// Assumes fpc_top drives key_index, hash_start and fuse_burn.
`timescale 1ns/1ps
module fpc_far (
  input logic sys_clk,
  input logic [15:0] key_index,
  input logic hash_start,
  input logic [511:0] hash_block,
  input logic fuse_burn,
  input logic [6:0] fuse_num,
  output logic [255:0] key_value,
  output logic hash_done = 1'b0,
  output logic [255:0] hash_digest = '0,
  output logic [87:0] fuse_state = '1
);
  int lat = 3; // Hash latency in cycles
  int cnt = 0; // Hash countdown
  // Key table lookup, one pattern per index
  assign key_value = {16{key_index ^ 16'h5a3c}};
  // Hash stand-in; digest toggles when not valid
  always @(posedge sys_clk) begin
    hash_done <= cnt == 1;
    hash_digest <= (cnt == 1) ? hash_block[511:256] ^ hash_block[255:0]
      : ~hash_digest;
    cnt <= hash_start ? lat : (cnt > 0 ? cnt - 1 : 0);
    // Burned fuse reads zero
    if (fuse_burn) fuse_state[fuse_num] <= 1'b0;
  end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the fuse personalization command engine.
// Assumes the far side model stands in for key table, hash and fuses.
`timescale 1ns/1ps
module testbench;
  localparam int LO = 20; // Shortened low supply burn
  localparam int HI = fpc_pkg::FPC_HI_CYC; // High supply burn
  localparam logic [127:0] SEED = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6979;
  logic sys_clk = 0, srst = 1, cmd_valid = 0, wdt_expire = 0;
  fpc_pkg::fpc_cmd_s cmd = '0;
  fpc_pkg::fpc_resp_s resp;
  logic cmd_ready, hash_start, hash_done, fuse_burn, digest_ready;
  logic io_ignore;
  logic [15:0] key_index;
  logic [255:0] key_value, hash_digest;
  logic [511:0] hash_block;
  logic [87:0] fuse_state;
  logic [6:0] fuse_num;
  int err_total = 0, compares = 0;
  fpc_top #(.LO_BURN_CYC(LO)) u_dut (.sys_clk, .srst, .cmd_valid, .cmd,
    .cmd_ready, .resp, .key_index, .key_value, .hash_start, .hash_block,
    .hash_done, .hash_digest, .fuse_state, .fuse_burn, .fuse_num,
    .wdt_expire, .digest_ready, .io_ignore);
  fpc_far u_far (.sys_clk, .key_index, .hash_start, .hash_block,
    .fuse_burn, .fuse_num, .key_value, .hash_done, .hash_digest,
    .fuse_state);
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic chk(logic [511:0] got, logic [511:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Map bit i goes to byte i/8, lsb first
  function automatic logic [127:0] mapd(logic [87:0] m);
    mapd = '0;
    for (int i = 0; i < 88; i++) mapd[120 - 8 * (i / 8) + i % 8] = m[i];
  endfunction
  // Wait up to 99 cycles for ready, then offer one command for one cycle
  task automatic send(logic [7:0] op, p1, logic [15:0] p2, logic [127:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 99) begin
      @(posedge sys_clk);
      #2 n++;
    end
    cmd_valid = 1;
    cmd = {op, p1, p2, d};
    @(posedge sys_clk);
    #2 cmd_valid = 0;
    cmd = ~cmd;
  endtask
  // Wait for an answer; exp is {seen, err, code}, zero for silence
  task automatic ans(int lim, logic [9:0] exp, output int c);
    logic s;
    s = 0;
    for (c = 0; c < lim && !s; c++) begin
      s = resp.valid === 1'b1;
      if (!s) @(posedge sys_clk);
      if (!s) #2;
    end
    chk(s ? {s, resp.err, resp.code} : 10'h0, exp);
  endtask
  task automatic pulse_wdt;
    wdt_expire = 1;
    @(posedge sys_clk);
    #2 wdt_expire = 0;
  endtask
  task automatic final_report;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    #(25 * 60000) err_total++;
    final_report;
  end
  initial begin
    logic [511:0] eb;
    logic [87:0] pad, want, f0;
    int c;
    repeat (12) @(posedge sys_clk);
    #2 srst = 0;
    // Digest build, seed lsb dropped
    eb = {{16{16'h0003 ^ 16'h5a3c}}, {64{1'b1}}, SEED[127:1], 1'b1, 64'h1bf};
    send(8'h20, 8'h00, 16'h0003, SEED);
    chk(cmd_ready, 1'b0);
    chk(hash_block, eb);
    ans(99, 10'h200, c);
    chk(digest_ready, 1'b1);
    $display("test digest done");
    // Encrypted burn of fuses 0, 15 and 86 at low supply
    pad = eb[511:424] ^ eb[255:168];
    want = 88'h40_0000_0000_0000_0000_8001;
    f0 = fuse_state;
    send(8'h10, 8'h01, 16'h8000, mapd(want ^ pad));
    ans(3000, 10'h200, c);
    chk(fuse_state, f0 & ~want);
    chk(c >= 3 * LO && c < 3 * LO + 200, 1'b1);
    pulse_wdt;
    chk(digest_ready, 1'b0);
    // Opcode outside this block is refused
    send(8'h02, 8'h00, 16'h0000, '0);
    ans(99, 10'h30f, c);
    $display("test encrypted burn done");
    // Plain burn at high supply, one fuse
    send(8'h10, 8'h00, 16'h0000, mapd(88'h2));
    ans(11000, 10'h200, c);
    chk(c >= HI && c < HI + 200, 1'b1);
    chk(fuse_state[1], 1'b0);
    // Plain low supply burn, lock fuse last
    send(8'h10, 8'h00, 16'h8000,
      mapd(88'h80_0000_0000_0000_0000_0004));
    ans(3000, 10'h200, c);
    chk(c >= 2 * LO && c < 2 * LO + 200, 1'b1);
    chk({fuse_state[87], fuse_state[2]}, 2'b00);
    $display("test plain burn done");
    // Locked part refuses both commands
    f0 = fuse_state;
    send(8'h20, 8'h00, 16'h0003, SEED);
    ans(99, 10'h30f, c);
    send(8'h10, 8'h00, 16'h0000, mapd(88'h8));
    ans(99, 10'h30f, c);
    repeat (20) @(posedge sys_clk);
    #2 chk({fuse_state, digest_ready}, {f0, 1'b0});
    $display("test lock done");
    // Pause aimed at another chip, then at this one
    send(8'h01, {4'h1, ~fuse_state[87:84]}, 16'h0000, '0);
    ans(99, 10'h20f, c);
    chk(io_ignore, 1'b0);
    send(8'h01, {4'h1, fuse_state[87:84]}, 16'h0000, '0);
    ans(40, 10'h0, c);
    pulse_wdt;
    repeat (4) @(posedge sys_clk);
    #2 chk(io_ignore, 1'b1);
    srst = 1;
    repeat (2) @(posedge sys_clk);
    #2 srst = 0;
    send(8'h01, 8'h00, 16'h0000, '0);
    ans(40, 10'h0, c);
    chk(io_ignore, 1'b1);
    $display("test pause done");
    final_report;
  end
endmodule
